// ===== hw/spsd_pkg.sv
`default_nettype none
package spsd_pkg;
	// ---------------------------------------------
	// Register addresses
	// ---------------------------------------------
	localparam logic [7:0] SPSD_A_DATA  = 8'h21;
	localparam logic [7:0] SPSD_A_CTRL  = 8'h22;
	localparam logic [7:0] SPSD_A_CSR   = 8'h23;
	localparam logic [7:0] SPSD_A_ISTAT = 8'h24;
	localparam logic [7:0] SPSD_A_IMASK = 8'h25;
	// ---------------------------------------------
	// Control field positions
	// ---------------------------------------------
	localparam int CR_IRQ_EN = 7;
	localparam int CR_OUT_EN = 6;
	localparam int CR_DIV2   = 5;
	localparam int CR_MASTER = 4;
	localparam int CR_CPOL   = 3;
	localparam int CR_CPHA   = 2;
	localparam int CR_RATE1  = 1;
	localparam int CR_RATE0  = 0;
	// ---------------------------------------------
	// Control/status field positions
	// ---------------------------------------------
	localparam int CS_DONE = 7;
	localparam int CS_WRITE_COLLISION_FLAG = 6;
	localparam int CS_OVR  = 5;
	localparam int CS_MODE_FAULT_FLAG = 4;
	localparam int CS_OD   = 2;
	localparam int CS_SSM  = 1;
	localparam int CS_SSI  = 0;
	// ---------------------------------------------
	// Interrupt status bits
	// ---------------------------------------------
	localparam int IS_DONE = 0;
	localparam int IS_OVR  = 1;
	localparam int IS_MODE_FAULT_FLAG = 2;
	localparam int IS_WRITE_COLLISION_FLAG = 3;
	// ---------------------------------------------
	// Reset values and counts
	// ---------------------------------------------
	localparam logic [7:0] SPSD_CTRL_RST  = 8'h00;
	localparam logic [2:0] SPSD_CSR_RST   = 3'h0;
	localparam logic [3:0] SPSD_IMASK_RST = 4'hf;
	localparam logic [3:0] SPSD_EDGE_LAST = 4'hf;
	localparam logic [6:0] SPSD_HALF_BASE = 7'h02;
	localparam int         LINK_PERIOD_NS = 125;

	typedef enum logic [1:0] {
		SPSD_IDLE,
		SPSD_XFER,
		SPSD_DONE
	} spsd_state_e;
endpackage : spsd_pkg
`default_nettype wire

// ===== hw/spsd_core.sv
// Functional notes
// - Transfer end sets done flag, interrupts.
// - Done clears: status read, then data access.
// - Data writes ignored while done unread.
// - Data write during transfer sets collision.
// - Byte ready while done set: overrun.
// - Status read clears overrun flag.
// - Master sees select low: mode fault.
// - Fault clears: status read, control write.
// - Output disable releases serial data out.
// - Select management picks internal select bit.
// - Internal select zero selects the slave.
// - Master data write starts one byte.
// - Reads return buffer copied at completion.
// - Data write loads shift register directly.
// - Mode fault clears output enable, master.
// - Four events share one gated interrupt.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module spsd_core (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output var  logic [7:0] rdata,
	output var  logic       irq,
	input  wire logic       sck_i,
	output var  logic       sck_o,
	output var  logic       sck_oe,
	input  wire logic       mosi_i,
	output var  logic       mosi_o,
	output var  logic       mosi_oe,
	input  wire logic       miso_i,
	output var  logic       miso_o,
	output var  logic       miso_oe,
	input  wire logic       sel_n_i
);
	import spsd_pkg::*;

	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	logic [3:0]  pin_raw;
	logic [3:0]  pin_q1_r;
	logic [3:0]  pin_q2_r;
	logic [3:0]  pin_q3_r;
	logic [3:0]  pin_f_r;
	logic [3:0]  pin_f_nxt;
	logic        sck_prev_r;

	assign pin_raw   = {sel_n_i, miso_i, mosi_i, sck_i};
	// Filtered level moves only when stages 2 and 3 agree
	assign pin_f_nxt = (pin_q2_r & pin_q3_r)
		| (pin_f_r & (pin_q2_r ^ pin_q3_r));

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_q1_r <= 4'hf;
			pin_q2_r <= 4'hf;
			pin_q3_r <= 4'hf;
			pin_f_r  <= 4'hf;
		end else begin
			pin_q1_r <= pin_raw;
			pin_q2_r <= pin_q1_r;
			pin_q3_r <= pin_q2_r;
			pin_f_r  <= pin_f_nxt;
		end
	end

	logic sck_f;
	logic mosi_f;
	logic miso_f;
	logic sel_n_f;

	assign sck_f   = pin_f_r[0];
	assign mosi_f  = pin_f_r[1];
	assign miso_f  = pin_f_r[2];
	assign sel_n_f = pin_f_r[3];

	// ---------------------------------------------
	// Registers and state
	// ---------------------------------------------
	logic [7:0]  ctrl_r;
	logic [7:0]  ctrl_nxt;
	logic [2:0]  csr_r;
	logic [2:0]  csr_nxt;
	logic        done_r;
	logic        done_nxt;
	logic        write_collision_flag_r;
	logic        write_collision_flag_nxt;
	logic        ovr_r;
	logic        ovr_nxt;
	logic        mode_fault_flag_r;
	logic        mode_fault_flag_nxt;
	logic        seen_done_r;
	logic        seen_write_collision_flag_r;
	logic        seen_mode_fault_flag_r;
	logic [3:0]  istat_r;
	logic [3:0]  istat_nxt;
	logic [3:0]  imask_r;
	logic [7:0]  rx_buf_r;
	logic [7:0]  shreg_r;
	logic [7:0]  shreg_nxt;
	logic        out_bit_r;
	logic        out_bit_nxt;
	logic        sck_r;
	logic        sck_nxt;
	logic [3:0]  edge_cnt_r;
	logic [3:0]  edge_cnt_nxt;
	logic [6:0]  div_cnt_r;
	logic [6:0]  div_cnt_nxt;
	spsd_state_e state_r;
	spsd_state_e state_nxt;

	// ---------------------------------------------
	// Bus decode
	// ---------------------------------------------
	logic a_data, a_ctrl, a_csr, a_istat, a_imask;
	logic dr_wr, dr_acc, cr_wr, cs_wr, cs_rd, is_wr, im_wr;

	assign a_data  = addr == SPSD_A_DATA;
	assign a_ctrl  = addr == SPSD_A_CTRL;
	assign a_csr   = addr == SPSD_A_CSR;
	assign a_istat = addr == SPSD_A_ISTAT;
	assign a_imask = addr == SPSD_A_IMASK;
	assign dr_wr   = wr_en & a_data;
	assign dr_acc  = (wr_en | rd_en) & a_data;
	assign cr_wr   = wr_en & a_ctrl;
	assign cs_wr   = wr_en & a_csr;
	assign cs_rd   = rd_en & a_csr;
	assign is_wr   = wr_en & a_istat;
	assign im_wr   = wr_en & a_imask;

	// ---------------------------------------------
	// Mode and select
	// ---------------------------------------------
	logic irq_en, out_en, master, cpol, cpha, sel_int_n, busy;

	assign irq_en    = ctrl_r[CR_IRQ_EN];
	assign out_en    = ctrl_r[CR_OUT_EN];
	assign master    = ctrl_r[CR_MASTER];
	assign cpol      = ctrl_r[CR_CPOL];
	assign cpha      = ctrl_r[CR_CPHA];
	assign sel_int_n = csr_r[CS_SSM] ? csr_r[CS_SSI] : sel_n_f;
	assign busy      = state_r == SPSD_XFER;

	// Half period of the master clock in ref_clk cycles
	function automatic logic [6:0] half_period(
		input logic [2:0] rate
	);
		logic [2:0] sh;
		sh = 3'h0;
		unique case (rate[1:0])
			2'b00: sh = 3'h1;
			2'b01: sh = 3'h2;
			2'b10: sh = 3'h4;
			2'b11: sh = 3'h5;
		endcase
		sh = sh - {2'b00, rate[2]};
		return SPSD_HALF_BASE << sh;
	endfunction : half_period

	logic [6:0] half_cnt;

	assign half_cnt = half_period({ctrl_r[CR_DIV2],
		ctrl_r[CR_RATE1], ctrl_r[CR_RATE0]});

	// ---------------------------------------------
	// Events
	// ---------------------------------------------
	logic fault_ev, wr_block, collide, load, m_edge, s_edge;
	logic sck_edge, leading, sample, drive, last_edge, desel;
	logic done_ev, done_clr, write_collision_flag_clr, ovr_ev, sin;

	assign fault_ev  = master & ~sel_int_n;
	assign wr_block  = done_r & ~seen_done_r;
	assign collide   = dr_wr & ~wr_block & busy;
	assign load      = dr_wr & ~wr_block & ~busy;
	assign m_edge    = busy & master & (div_cnt_r == 7'h00);
	assign s_edge    = ~master & out_en & ~sel_int_n
		& (sck_f ^ sck_prev_r);
	assign sck_edge  = m_edge | s_edge;
	assign leading   = ~edge_cnt_r[0];
	assign sample    = sck_edge & (leading ^ cpha);
	assign drive     = sck_edge & ~(leading ^ cpha);
	assign last_edge = sck_edge & (edge_cnt_r == SPSD_EDGE_LAST);
	assign desel     = ~master & sel_int_n;
	assign done_ev   = state_r == SPSD_DONE;
	assign done_clr  = dr_acc & seen_done_r;
	assign write_collision_flag_clr  = dr_acc & seen_write_collision_flag_r;
	assign ovr_ev    = done_ev & done_r & ~done_clr;
	assign sin       = master ? miso_f : mosi_f;

	// ---------------------------------------------
	// Transfer sequencer
	// ---------------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SPSD_IDLE: begin
				if (load & master & out_en) begin
					state_nxt = SPSD_XFER;
				end else if (s_edge) begin
					state_nxt = SPSD_XFER;
				end
			end
			SPSD_XFER: begin
				if (last_edge) begin
					state_nxt = SPSD_DONE;
				end
			end
			SPSD_DONE: begin
				state_nxt = SPSD_IDLE;
			end
		endcase
		if (fault_ev | desel | ~out_en) begin
			state_nxt = SPSD_IDLE;
		end
	end

	assign shreg_nxt = load ? wdata
		: sample ? {shreg_r[6:0], sin} : shreg_r;

	assign out_bit_nxt = (load & ~cpha) ? wdata[7]
		: drive ? shreg_r[7] : out_bit_r;

	assign edge_cnt_nxt = (load | desel | ~busy & ~s_edge) ? 4'h0
		: sck_edge ? edge_cnt_r + 4'h1 : edge_cnt_r;

	assign div_cnt_nxt = (~busy | m_edge) ? half_cnt - 7'h01
		: div_cnt_r - 7'h01;

	assign sck_nxt = ~(busy & master) ? cpol
		: m_edge ? ~sck_r : sck_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r    <= SPSD_IDLE;
			shreg_r    <= 8'h00;
			out_bit_r  <= 1'b0;
			edge_cnt_r <= 4'h0;
			div_cnt_r  <= 7'h00;
			sck_r      <= 1'b0;
			// Same level as the synchroniser, no false edge
			sck_prev_r <= 1'b1;
		end else begin
			state_r    <= state_nxt;
			shreg_r    <= shreg_nxt;
			out_bit_r  <= out_bit_nxt;
			edge_cnt_r <= edge_cnt_nxt;
			div_cnt_r  <= div_cnt_nxt;
			sck_r      <= sck_nxt;
			sck_prev_r <= sck_f;
		end
	end

	// Receive buffer, held on overrun
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_buf_r <= 8'h00;
		end else if (done_ev & ~ovr_ev) begin
			rx_buf_r <= shreg_r;
		end
	end

	// ---------------------------------------------
	// Flags
	// ---------------------------------------------
	assign done_nxt = done_ev | (done_r & ~done_clr);
	assign write_collision_flag_nxt = collide | (write_collision_flag_r & ~write_collision_flag_clr);
	assign ovr_nxt  = ovr_ev | (ovr_r & ~cs_rd);
	assign mode_fault_flag_nxt = fault_ev
		| (mode_fault_flag_r & ~(cr_wr & seen_mode_fault_flag_r));

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			done_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			ovr_r  <= 1'b0;
			mode_fault_flag_r <= 1'b0;
		end else begin
			done_r <= done_nxt;
			write_collision_flag_r <= write_collision_flag_nxt;
			ovr_r  <= ovr_nxt;
			mode_fault_flag_r <= mode_fault_flag_nxt;
		end
	end

	// Status read arms the clear sequences
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			seen_done_r <= 1'b0;
			seen_write_collision_flag_r <= 1'b0;
			seen_mode_fault_flag_r <= 1'b0;
		end else begin
			seen_done_r <= (seen_done_r & ~dr_acc) | (cs_rd & done_r);
			seen_write_collision_flag_r <= (seen_write_collision_flag_r & ~dr_acc) | (cs_rd & write_collision_flag_r);
			seen_mode_fault_flag_r <= (seen_mode_fault_flag_r & ~cr_wr) | (cs_rd & mode_fault_flag_r);
		end
	end

	// ---------------------------------------------
	// Control registers
	// ---------------------------------------------
	always_comb begin
		ctrl_nxt = cr_wr ? wdata : ctrl_r;
		if (fault_ev) begin
			ctrl_nxt[CR_OUT_EN] = 1'b0;
			ctrl_nxt[CR_MASTER] = 1'b0;
		end
	end

	// Reserved bit 3 and flag bits are not stored
	assign csr_nxt = cs_wr ? wdata[2:0] : csr_r;

	assign istat_nxt = {collide, fault_ev, ovr_ev, done_ev}
		| (istat_r & ~(is_wr ? wdata[3:0] : 4'h0));

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r  <= SPSD_CTRL_RST;
			csr_r   <= SPSD_CSR_RST;
			istat_r <= 4'h0;
			imask_r <= SPSD_IMASK_RST;
		end else begin
			ctrl_r  <= ctrl_nxt;
			csr_r   <= csr_nxt;
			istat_r <= istat_nxt;
			if (im_wr) begin
				imask_r <= wdata[3:0];
			end
		end
	end

	// ---------------------------------------------
	// Read data
	// ---------------------------------------------
	logic [7:0] csr_view;
	logic [7:0] rd_mux;

	assign csr_view = {done_r, write_collision_flag_r, ovr_r, mode_fault_flag_r, 1'b0, csr_r};
	assign rd_mux = a_data  ? rx_buf_r
		: a_ctrl  ? ctrl_r
		: a_csr   ? csr_view
		: a_istat ? {4'h0, istat_r}
		: a_imask ? {4'h0, imask_r} : 8'h00;

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	logic irq_nxt;

	assign irq_nxt = irq_en & |(istat_nxt & imask_r);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata   <= 8'h00;
			irq     <= 1'b0;
			sck_oe  <= 1'b0;
			mosi_oe <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			rdata   <= rd_en ? rd_mux : 8'h00;
			irq     <= irq_nxt;
			sck_oe  <= ctrl_nxt[CR_OUT_EN] & ctrl_nxt[CR_MASTER];
			mosi_oe <= ctrl_nxt[CR_OUT_EN] & ctrl_nxt[CR_MASTER]
				& ~csr_nxt[CS_OD];
			miso_oe <= ctrl_nxt[CR_OUT_EN] & ~ctrl_nxt[CR_MASTER]
				& ~csr_nxt[CS_OD] & ~sel_int_n;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sck_o  <= 1'b0;
			mosi_o <= 1'b0;
			miso_o <= 1'b0;
		end else begin
			sck_o  <= sck_nxt;
			mosi_o <= out_bit_nxt;
			miso_o <= out_bit_nxt;
		end
	end
endmodule : spsd_core
`default_nettype wire

// ===== test/spsd_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module spsd_core_assertions (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	input wire logic       irq,
	input wire logic       sck_oe,
	input wire logic       mosi_oe,
	input wire logic       miso_oe
);
	import spsd_pkg::*;
	// ----------------------------
	// Shadow of written settings
	// ----------------------------
	logic       irq_en_r, mst_r, od_r, ssm_r, ssi_r, rcsr_r, rctl_r, mode_fault_flag_r;
	logic [3:0] flt_r;
	wire        wr_ctl = wr_en && addr == SPSD_A_CTRL;
	wire        wr_csr = wr_en && addr == SPSD_A_CSR;
	wire        flt    = mst_r && ssm_r && !ssi_r;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			{irq_en_r, mst_r, od_r, ssm_r, ssi_r} <= 5'h00;
		end else begin
			if (wr_ctl) {irq_en_r, mst_r} <= {wdata[CR_IRQ_EN], wdata[CR_MASTER]};
			if (wr_csr) {od_r, ssm_r, ssi_r} <= wdata[2:0];
		end
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			{rcsr_r, rctl_r, mode_fault_flag_r} <= 3'h0;
			flt_r <= 4'h0;
		end else begin
			rcsr_r <= rd_en && addr == SPSD_A_CSR;
			rctl_r <= rd_en && addr == SPSD_A_CTRL;
			mode_fault_flag_r <= !wr_ctl && (mode_fault_flag_r || (rcsr_r && rdata[CS_MODE_FAULT_FLAG]));
			flt_r  <= !flt ? 4'h0 : flt_r + {3'h0, flt_r != 4'hf};
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_RDATA_IDLE: assert property (!$past(rd_en) || $past(addr) < SPSD_A_DATA
		|| $past(addr) > SPSD_A_IMASK |-> rdata == 8'h00) else $error("rdata not zero");
	AST_IRQ_GATE: assert property (!irq_en_r && !$past(irq_en_r) |-> !irq)
		else $error("irq while disabled");
	AST_DONE_IRQ: assert property (rcsr_r && rdata[CS_DONE] && irq_en_r && $past(irq_en_r)
		|-> irq) else $error("done flag without irq");
	AST_OVR_CLEAR: assert property (rcsr_r && $past(rcsr_r, 2) |-> !rdata[CS_OVR])
		else $error("overrun survived status read");
	AST_OUT_DISABLE: assert property (od_r && $past(od_r) |-> !mosi_oe && !miso_oe)
		else $error("data out driven while disabled");
	AST_OE_EXCL: assert property (miso_oe |-> !mosi_oe && !sck_oe)
		else $error("slave and master outputs both on");
	AST_MODE_FAULT_FLAG_SET: assert property (rcsr_r && flt_r >= 4'hc |-> rdata[CS_MODE_FAULT_FLAG])
		else $error("mode fault not flagged");
	AST_MODE_FAULT_FLAG_CTRL: assert property (rctl_r && mode_fault_flag_r
		|-> !rdata[CR_OUT_EN] && !rdata[CR_MASTER]) else $error("control kept after fault");
	cover property (rcsr_r && rdata[CS_OVR]);
	cover property (rcsr_r && rdata[CS_WRITE_COLLISION_FLAG]);
	cover property (rctl_r && mode_fault_flag_r);
endmodule : spsd_core_assertions
bind spsd_core spsd_core_assertions spsd_core_assertions_i (.ref_clk, .nrst, .addr, .wdata,
	.wr_en, .rd_en, .rdata, .irq, .sck_oe, .mosi_oe, .miso_oe);
`default_nettype wire

// ===== test/spsd_link_master.sv
`timescale 1ns/100ps
`default_nettype none
module spsd_link_master (
	output var  logic sck,
	output var  logic mosi,
	output var  logic sel_n,
	input  wire logic miso_o,
	input  wire logic miso_oe
);
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		sel_n = 1'b1;
	end
	// ----------------------------
	// One byte, MSB first, clock idles low
	// ----------------------------
	task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
		#3 sel_n = 1'b0;
		mosi = tx[7];
		#250;
		for (int i = 7; i >= 0; i--) begin
			#62.5 sck = 1'b1;
			// Released line reads inverted
			rx[i] = miso_oe ? miso_o : ~miso_o;
			#62.5 sck = 1'b0;
			mosi = i > 0 ? tx[i-1] : ~mosi;
		end
		#250 sel_n = 1'b1;
	endtask : frame
endmodule : spsd_link_master
`default_nettype wire

// ===== test/spsd_core_bench.sv
`timescale 1ns/100ps
`default_nettype none
module spsd_core_bench;
	import spsd_pkg::*;
	logic       ref_clk, nrst, wr_en, rd_en, sck, mosi, sel_n;
	logic       irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic [7:0] addr, wdata, rdata, rx;
	int         err_count, num_checks;
	wire        sck_w  = sck_oe ? sck_o : sck;
	wire        mosi_w = mosi_oe ? mosi_o : mosi;
	spsd_core spsd_core_i (.ref_clk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq,
		.sck_i(sck_w), .sck_o, .sck_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe,
		.miso_i(~mosi_w), .miso_o, .miso_oe, .sel_n_i(sel_n));
	spsd_link_master spsd_link_master_i (.sck, .mosi, .sel_n, .miso_o, .miso_oe);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ----------------------------
	// Bus and check helpers
	// ----------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 chk(rdata & msk, exp);
	endtask : rd
	task automatic end_sim();
		if (err_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	task automatic wait_irq();
		for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge ref_clk);
		if (irq !== 1'b1) begin
			err_count++;
			$display("MISMATCH %0t no interrupt", $time);
			end_sim();
		end
	endtask : wait_irq
	// ----------------------------
	// Scenarios
	// ----------------------------
	task automatic t_reset();
		rd(SPSD_A_CTRL, 8'h00, 8'hf0);
		rd(SPSD_A_CSR, 8'h00, 8'hff);
		rd(SPSD_A_IMASK, 8'h0f, 8'h0f);
		rd(8'h30, 8'h00, 8'hff);
	endtask : t_reset
	task automatic t_slave();
		wr(SPSD_A_CTRL, 8'hc0);
		wr(SPSD_A_DATA, 8'ha5);
		spsd_link_master_i.frame(8'h3c, rx);
		chk(rx, 8'ha5);
		chk({7'h00, irq}, 8'h01);
		rd(SPSD_A_CSR, 8'h80, 8'hf0);
		rd(SPSD_A_DATA, 8'h3c, 8'hff);
		rd(SPSD_A_CSR, 8'h00, 8'h80);
		wr(SPSD_A_ISTAT, 8'h0f);
		repeat (2) @(posedge ref_clk);
		#1 chk({7'h00, irq}, 8'h00);
	endtask : t_slave
	task automatic t_overrun();
		spsd_link_master_i.frame(8'h11, rx);
		wr(SPSD_A_DATA, 8'h77);
		spsd_link_master_i.frame(8'h22, rx);
		chk({7'h00, rx === 8'h77}, 8'h00);
		rd(SPSD_A_CSR, 8'ha0, 8'hf0);
		rd(SPSD_A_CSR, 8'h80, 8'ha0);
		rd(SPSD_A_DATA, 8'h11, 8'hff);
		rd(SPSD_A_CSR, 8'h00, 8'h80);
	endtask : t_overrun
	task automatic t_write_collision_flag();
		fork
			spsd_link_master_i.frame(8'h5a, rx);
			begin
				repeat (60) @(posedge ref_clk);
				wr(SPSD_A_DATA, 8'he7);
			end
		join
		rd(SPSD_A_CSR, 8'hc0, 8'hf0);
		rd(SPSD_A_DATA, 8'h5a, 8'hff);
		rd(SPSD_A_CSR, 8'h00, 8'hc0);
		wr(SPSD_A_ISTAT, 8'h0f);
	endtask : t_write_collision_flag
	task automatic t_mode_fault_flag();
		wr(SPSD_A_CSR, 8'h03);
		wr(SPSD_A_CTRL, 8'hd0);
		wr(SPSD_A_CSR, 8'h02);
		repeat (16) @(posedge ref_clk);
		#1 chk({7'h00, irq}, 8'h01);
		rd(SPSD_A_CSR, 8'h10, 8'hf0);
		rd(SPSD_A_CTRL, 8'h80, 8'hd0);
		wr(SPSD_A_CTRL, 8'h80);
		rd(SPSD_A_CSR, 8'h00, 8'h10);
		wr(SPSD_A_ISTAT, 8'h0f);
	endtask : t_mode_fault_flag
	task automatic t_master();
		wr(SPSD_A_CSR, 8'h03);
		wr(SPSD_A_CTRL, 8'hd1);
		repeat (2) @(posedge ref_clk);
		#1 chk({6'h00, mosi_oe, sck_oe}, 8'h03);
		wr(SPSD_A_DATA, 8'h96);
		wait_irq();
		rd(SPSD_A_CSR, 8'h80, 8'hf0);
		rd(SPSD_A_DATA, 8'h69, 8'hff);
		wr(SPSD_A_CSR, 8'h07);
		repeat (2) @(posedge ref_clk);
		#1 chk({7'h00, mosi_oe}, 8'h00);
	endtask : t_master
	task automatic t_phase();
		wr(SPSD_A_ISTAT, 8'h0f);
		wr(SPSD_A_CSR, 8'h03);
		wr(SPSD_A_IMASK, 8'h0e);
		wr(SPSD_A_CTRL, 8'hdd);
		repeat (2) @(posedge ref_clk);
		#1 chk({7'h00, sck_o}, 8'h01);
		wr(SPSD_A_DATA, 8'h3c);
		repeat (200) @(posedge ref_clk);
		#1 chk({6'h00, sck_o, irq}, 8'h02);
		rd(SPSD_A_ISTAT, 8'h01, 8'h0f);
		wr(SPSD_A_IMASK, 8'h0f);
		repeat (2) @(posedge ref_clk);
		#1 chk({7'h00, irq}, 8'h01);
		rd(SPSD_A_CSR, 8'h80, 8'hf0);
		rd(SPSD_A_DATA, 8'hc3, 8'hff);
	endtask : t_phase
	initial begin
		{nrst, wr_en, rd_en} = 3'h0;
		{addr, wdata} = 16'h0000;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		t_reset();
		t_slave();
		t_overrun();
		t_write_collision_flag();
		t_mode_fault_flag();
		t_master();
		t_phase();
		end_sim();
	end
endmodule : spsd_core_bench
`default_nettype wire
